//--- rtl/osc_program_measure_ctrl.sv
// Clock RAM, generator programming, post-dividers and clock measurement
`timescale 1ns/1ns
//
// Contract
// - Software writes a RAM location to the pointer register and then moves data through the window register.
// - Each window access reads or writes the RAM byte the pointer selects.
// - Writing one to command bit 0 sends clock RAM bytes 0x08 to 0x57 to the generator.
// - Command bit 0 returns to zero by itself after being written as one.
// - Command bits 1 to 4 pick channel 1 to 4 as the clock to measure.
// - Command bit 6 makes status bits 31..8 show command bits 23..0, else the measured value.
// - With command bit 7 at zero a command write keeps all post-dividers and ignores bits 23..8.
// - With command bit 7 at one a command write loads the four 4-bit post-dividers from bits 23..8.
// - Status bit 0 is zero while programming runs and one once it has ended.
// - Status bit 1 is one when programming the generator failed.
// - Status bit 2 is zero while a measurement runs and one once it completes.
// - One offset takes command writes and gives status reads, neither touching the other.
// - A post-divider value n divides the generator clock by two to the power n.
module osc_program_measure_ctrl
   import osc_ctrl_pkg::*;
#(
   parameter int GATE_CYC = MEAS_GATE_CYC
)(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_srst,
   input  wire osc_ctrl_pkg::wb_req_t i_wb,
   output osc_ctrl_pkg::wb_rsp_t     o_wb,
   input  wire logic [3:0]           i_gen_clk,
   output logic      [3:0]           o_chan_clk,
   input  wire logic                 i_scl,
   input  wire logic                 i_sda,
   output osc_ctrl_pkg::ser_pins_t   o_pins,
   output logic                      o_irq
);

   logic [7:0]                 ram [RAM_DEPTH];
   logic [7:0]                 ram_ptr;
   logic [CMD_SHADOW_W-1:0]    cmd_shadow;
   logic [PDIV_W-1:0]          pdiv [NUM_CHAN];
   logic                       acc;
   logic                       wr;
   logic [31:0]                wmask;
   logic [31:0]                wdat;
   logic                       hit_ptr;
   logic                       hit_data;
   logic                       hit_cmd;
   logic                       hit_istat;
   logic                       hit_imask;
   logic [31:0]                rdat;
   logic                       cmd_wr;
   logic                       prog_start;
   logic                       prog_done;
   logic                       prog_err;
   logic                       ser_busy;
   logic                       ser_done;
   logic                       ser_err;
   logic [7:0]                 ser_adr;
   logic [1:0]                 meas_ch;
   logic                       meas_busy;
   logic                       meas_done;
   logic [23:0]                meas_val;
   logic [23:0]                meas_cnt;
   logic [31:0]                gate_cnt;
   logic [3:0]                 chan_d;
   logic                       meas_end;
   logic [IRQ_W-1:0]           irq_stat;
   logic [IRQ_W-1:0]           irq_mask;
   logic [IRQ_W-1:0]           irq_ev;
   logic [IRQ_W-1:0]           next_irq_stat;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   assign acc   = i_wb.cyc && i_wb.stb && !o_wb.ack;
   assign wr    = acc && i_wb.we;
   assign wmask = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}},
                   {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
   // Unselected byte lanes are seen as zero
   assign wdat  = i_wb.dat & wmask;

   always_comb begin
      hit_ptr   = 1'b0;
      hit_data  = 1'b0;
      hit_cmd   = 1'b0;
      hit_istat = 1'b0;
      hit_imask = 1'b0;
      if (i_wb.adr == OFF_RAM_PTR) begin
         hit_ptr = 1'b1;
      end else if (i_wb.adr == OFF_RAM_DATA) begin
         hit_data = 1'b1;
      end else if (i_wb.adr == OFF_CMD_STAT) begin
         hit_cmd = 1'b1;
      end else if (i_wb.adr == OFF_IRQ_STAT) begin
         hit_istat = 1'b1;
      end else if (i_wb.adr == OFF_IRQ_MASK) begin
         hit_imask = 1'b1;
      end
   end

   always_comb begin
      rdat = 32'h0000_0000;
      if (hit_ptr) begin
         rdat = {24'h00_0000, ram_ptr};
      end else if (hit_data) begin
         rdat = {24'h00_0000, ram[ram_ptr]};
      end else if (hit_cmd) begin
         rdat[ST_PROG_DONE] = prog_done;
         rdat[ST_PROG_ERR]  = prog_err;
         rdat[ST_MEAS_DONE] = meas_done;
         rdat[31:ST_VAL_LO] = cmd_shadow[CMD_RB_SEL] ?
                              cmd_shadow : meas_val;
      end else if (hit_istat) begin
         rdat = {29'h000_0000, irq_stat};
      end else if (hit_imask) begin
         rdat = {29'h000_0000, irq_mask};
      end
   end

   // Answer one cycle after the request, drop it the cycle after
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_wb <= '0;
      end else begin
         o_wb.ack <= acc;
         o_wb.dat <= (acc && !i_wb.we) ? rdat : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Clock RAM and pointer
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ram_ptr <= RAM_PTR_RST;
      end else if (wr && hit_ptr && i_wb.sel[0]) begin
         ram_ptr <= wdat[7:0];
      end
   end

   // Cleared at reset so reads never return unknowns
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         for (int i = 0; i < RAM_DEPTH; i++) begin
            ram[i] <= 8'h00;
         end
      end else if (wr && hit_data && i_wb.sel[0]) begin
         ram[ram_ptr] <= wdat[7:0];
      end
   end

   // ****************************************************************
   // Command word
   // ****************************************************************
   assign cmd_wr = wr && hit_cmd;

   // Bit 0 is never stored, so it reads back as zero
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         cmd_shadow <= CMD_SHADOW_RST;
      end else if (cmd_wr) begin
         cmd_shadow[7:1] <= wdat[7:1];
         if (wdat[CMD_PDIV_SET]) begin
            cmd_shadow[23:8] <= wdat[23:8];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            pdiv[c] <= '0;
         end
      end else if (cmd_wr && wdat[CMD_PDIV_SET]) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            pdiv[c] <= wdat[CMD_PDIV_LO + c*PDIV_W +: PDIV_W];
         end
      end
   end

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_div
      chan_post_div #(
         .EXP_W (PDIV_W),
         .CNT_W (15)
      ) u_div (
         .i_clk_sys (i_clk_sys),
         .i_srst    (i_srst),
         .i_clk_in  (i_gen_clk[g]),
         .i_exp     (pdiv[g]),
         .o_clk_out (o_chan_clk[g])
      );
   end

   // ****************************************************************
   // Generator programming
   // ****************************************************************
   // A start while a transfer runs is dropped; the RAM is read live
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prog_start <= 1'b0;
      end else begin
         prog_start <= cmd_wr && wdat[CMD_PROG] && !ser_busy;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prog_done <= 1'b1;
         prog_err  <= 1'b0;
      end else if (prog_start) begin
         prog_done <= 1'b0;
         prog_err  <= 1'b0;
      end else if (ser_done) begin
         prog_done <= 1'b1;
         prog_err  <= ser_err;
      end
   end

   osc_serial_writer u_ser (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_start   (prog_start),
      .i_ram_dat (ram[ser_adr]),
      .o_ram_adr (ser_adr),
      .i_scl     (i_scl),
      .i_sda     (i_sda),
      .o_pins    (o_pins),
      .o_busy    (ser_busy),
      .o_done    (ser_done),
      .o_err     (ser_err)
   );

   // ****************************************************************
   // Clock measurement
   // ****************************************************************
   // Edges counted over a 100 ms gate give the frequency over ten;
   // a sampled clock above half the system rate cannot be seen
   assign meas_end = meas_busy && (gate_cnt == 32'(GATE_CYC - 1));

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         chan_d <= 4'h0;
      end else begin
         chan_d <= o_chan_clk;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         meas_ch   <= 2'd0;
         meas_busy <= 1'b0;
         meas_done <= 1'b0;
         meas_cnt  <= 24'h00_0000;
         gate_cnt  <= 32'h0000_0000;
         meas_val  <= 24'h00_0000;
      end else if (cmd_wr && (wdat[4:1] != 4'h0)) begin
         meas_busy <= 1'b1;
         meas_done <= 1'b0;
         meas_cnt  <= 24'h00_0000;
         gate_cnt  <= 32'h0000_0000;
         if (wdat[CMD_MEAS_LO]) begin
            meas_ch <= 2'd0;
         end else if (wdat[CMD_MEAS_LO + 1]) begin
            meas_ch <= 2'd1;
         end else if (wdat[CMD_MEAS_LO + 2]) begin
            meas_ch <= 2'd2;
         end else begin
            meas_ch <= 2'd3;
         end
      end else if (meas_busy) begin
         gate_cnt <= gate_cnt + 1'b1;
         if (o_chan_clk[meas_ch] && !chan_d[meas_ch]) begin
            meas_cnt <= meas_cnt + 1'b1;
         end
         if (meas_end) begin
            meas_busy <= 1'b0;
            meas_done <= 1'b1;
            meas_val  <= meas_cnt;
         end
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   assign irq_ev = {meas_end, ser_done && ser_err, ser_done};

   // A new event wins over a clear in the same cycle
   always_comb begin
      next_irq_stat = irq_stat;
      if (wr && hit_istat) begin
         next_irq_stat = irq_stat & ~wdat[IRQ_W-1:0];
      end
      next_irq_stat = next_irq_stat | irq_ev;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wr && hit_imask && i_wb.sel[0]) begin
         irq_mask <= wdat[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(next_irq_stat & irq_mask);
      end
   end

endmodule : osc_program_measure_ctrl

//--- rtl/osc_ctrl_pkg.sv
// Shared constants, carrier structs and state codes for the oscillator control
package osc_ctrl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_NS        = 50;
   localparam int SER_QTR_NS    = 2500;
   localparam int SER_QTR_CYC   = (SER_QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int MEAS_GATE_NS  = 100_000_000;
   localparam int MEAS_GATE_CYC = MEAS_GATE_NS / CLK_NS;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFF_RAM_PTR   = 8'ha0;
   localparam logic [7:0] OFF_RAM_DATA  = 8'ha4;
   localparam logic [7:0] OFF_CMD_STAT  = 8'ha8;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'hac;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'hb0;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CMD_PROG      = 0;
   localparam int CMD_MEAS_LO   = 1;
   localparam int CMD_RB_SEL    = 6;
   localparam int CMD_PDIV_SET  = 7;
   localparam int CMD_PDIV_LO   = 8;
   localparam int CMD_SHADOW_W  = 24;
   localparam int PDIV_W        = 4;
   localparam int NUM_CHAN      = 4;
   localparam int ST_PROG_DONE  = 0;
   localparam int ST_PROG_ERR   = 1;
   localparam int ST_MEAS_DONE  = 2;
   localparam int ST_VAL_LO     = 8;
   localparam int IRQ_W         = 3;

   // ****************************************************************
   // Reset values and RAM layout
   // ****************************************************************
   localparam logic [7:0]  RAM_PTR_RST    = 8'h00;
   localparam logic [23:0] CMD_SHADOW_RST = 24'h00_0000;
   localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
   localparam int          RAM_DEPTH      = 256;
   localparam logic [7:0]  RAM_FIRST      = 8'h08;
   localparam logic [7:0]  RAM_LAST       = 8'h57;
   localparam logic [6:0]  SER_BYTES      = 7'h52;
   localparam logic [6:0]  SER_DEV_ADDR   = 7'h55;

   // ****************************************************************
   // Carriers and states
   // ****************************************************************
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
   } wb_rsp_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } ser_pins_t;

   typedef enum logic [1:0] {
      SER_IDLE  = 2'b00,
      SER_START = 2'b01,
      SER_BITS  = 2'b11,
      SER_STOP  = 2'b10
   } ser_state_t;

endpackage : osc_ctrl_pkg

//--- rtl/chan_post_div.sv
// Power-of-two post-divider for one channel clock
`timescale 1ns/1ns
module chan_post_div
   import osc_ctrl_pkg::*;
#(
   parameter int EXP_W = 4,
   parameter int CNT_W = 15
)(
   input  wire logic             i_clk_sys,
   input  wire logic             i_srst,
   input  wire logic             i_clk_in,
   input  wire logic [EXP_W-1:0] i_exp,
   output logic                  o_clk_out
);

   logic             in_d;
   logic [CNT_W-1:0] edge_cnt;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         in_d <= 1'b0;
      end else begin
         in_d <= i_clk_in;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         edge_cnt <= '0;
      end else if (i_clk_in && !in_d) begin
         edge_cnt <= edge_cnt + 1'b1;
      end
   end

   // Bit n-1 of the edge count has a period of 2^n input periods
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_clk_out <= 1'b0;
      end else if (i_exp == '0) begin
         o_clk_out <= i_clk_in;
      end else begin
         o_clk_out <= edge_cnt[i_exp - 1'b1];
      end
   end

endmodule : chan_post_div

//--- rtl/osc_serial_writer.sv
// Two-wire serial writer that copies the clock RAM into the generator
`timescale 1ns/1ns
module osc_serial_writer
   import osc_ctrl_pkg::*;
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_srst,
   input  wire logic              i_start,
   input  wire logic [7:0]        i_ram_dat,
   output logic      [7:0]        o_ram_adr,
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output osc_ctrl_pkg::ser_pins_t o_pins,
   output logic                   o_busy,
   output logic                   o_done,
   output logic                   o_err
);

   ser_state_t  state;
   logic [7:0]  qtr_cnt;
   logic        tick;
   logic        hold;
   logic [1:0]  phase;
   logic [3:0]  bit_idx;
   logic [6:0]  byte_idx;
   logic [7:0]  cur_byte;
   logic        nack;

   // ****************************************************************
   // Quarter-bit enable
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_srst || state == SER_IDLE) begin
         qtr_cnt <= '0;
      end else if (qtr_cnt == 8'(SER_QTR_CYC - 1)) begin
         qtr_cnt <= '0;
      end else begin
         qtr_cnt <= qtr_cnt + 1'b1;
      end
   end
   assign tick = (state != SER_IDLE) && (qtr_cnt == 8'(SER_QTR_CYC - 1));
   // A slave stretching the clock holds the high phase
   assign hold = (phase == 2'd2) && !o_pins.scl_oe && !i_scl;

   assign o_ram_adr = RAM_FIRST + {1'b0, byte_idx} - 8'h02;
   always_comb begin
      if (byte_idx == 7'h00) begin
         cur_byte = {SER_DEV_ADDR, 1'b0};
      end else if (byte_idx == 7'h01) begin
         cur_byte = RAM_FIRST;
      end else begin
         cur_byte = i_ram_dat;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state    <= SER_IDLE;
         phase    <= 2'd0;
         bit_idx  <= 4'd0;
         byte_idx <= 7'd0;
         nack     <= 1'b0;
         o_pins   <= '0;
         o_done   <= 1'b0;
         o_err    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         o_err  <= 1'b0;
         if (state == SER_IDLE) begin
            phase <= 2'd0;
            if (i_start) begin
               state    <= SER_START;
               byte_idx <= 7'd0;
               bit_idx  <= 4'd0;
               nack     <= 1'b0;
            end
         end else if (tick && !hold) begin
            phase <= phase + 1'b1;
            case (state)
               SER_START: begin
                  if (phase == 2'd1) o_pins.sda_oe <= 1'b1;
                  if (phase == 2'd2) o_pins.scl_oe <= 1'b1;
                  if (phase == 2'd3) state <= SER_BITS;
               end
               SER_BITS: begin
                  case (phase)
                     2'd0: o_pins.sda_oe <= (bit_idx != 4'd8) &&
                                            !cur_byte[3'(4'd7 - bit_idx)];
                     2'd1: o_pins.scl_oe <= 1'b0;
                     2'd2: if (bit_idx == 4'd8) nack <= i_sda;
                     default: begin
                        o_pins.scl_oe <= 1'b1;
                        if (bit_idx != 4'd8) begin
                           bit_idx <= bit_idx + 1'b1;
                        end else if (nack ||
                                     byte_idx == SER_BYTES - 7'd1) begin
                           state <= SER_STOP;
                        end else begin
                           bit_idx  <= 4'd0;
                           byte_idx <= byte_idx + 1'b1;
                        end
                     end
                  endcase
               end
               SER_STOP: begin
                  if (phase == 2'd0) o_pins.sda_oe <= 1'b1;
                  if (phase == 2'd1) o_pins.scl_oe <= 1'b0;
                  if (phase == 2'd2) o_pins.sda_oe <= 1'b0;
                  if (phase == 2'd3) begin
                     state  <= SER_IDLE;
                     o_done <= 1'b1;
                     o_err  <= nack;
                  end
               end
               default: state <= SER_IDLE;
            endcase
         end
      end
   end

   assign o_busy = (state != SER_IDLE);

endmodule : osc_serial_writer

//--- dv/osc_gen_model.sv
// Behavioural model of the clock generator on the two-wire line
`timescale 1ns/1ns
module osc_gen_model (
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_nack,
   output logic            o_sda_oe,
   output logic [7:0]      o_first
);
   int         bits = 0;
   int         nbyte = 0;
   logic [7:0] sh = 8'h00;
   initial o_sda_oe = 1'b0;
   initial o_first = 8'h00;
   // Start condition resets the byte framing
   always @(negedge i_sda) if (i_scl) begin
      bits = 0;
      nbyte = 0;
   end
   always @(posedge i_scl) begin
      if (bits < 8) sh = {sh[6:0], i_sda};
      bits++;
   end
   // Ack slot: pull data low unless told to refuse
   always @(negedge i_scl) begin
      if (bits == 8) begin
         o_sda_oe = !i_nack;
         if (nbyte == 0) o_first = sh;
      end else if (bits == 9) begin
         o_sda_oe = 1'b0;
         bits = 0;
         nbyte++;
      end
   end
endmodule : osc_gen_model

//--- dv/osc_ctrl_chk_sva.sv
// Port checks for the oscillator control block
`timescale 1ns/1ns
module osc_ctrl_chk
   import osc_ctrl_pkg::*;
#(
   parameter int GATE_CYC = 200
)(
   input wire logic                   i_clk_sys,
   input wire logic                   i_srst,
   input wire osc_ctrl_pkg::wb_req_t  i_wb,
   input wire osc_ctrl_pkg::wb_rsp_t  o_wb,
   input wire osc_ctrl_pkg::ser_pins_t o_pins,
   input wire logic                   o_irq
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   logic req;
   logic rdc;
   assign req = i_wb.cyc && i_wb.stb && !o_wb.ack;
   assign rdc = o_wb.ack && !i_wb.we;
   property p_ack_next; req |=> o_wb.ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack");
   property p_ack_once; o_wb.ack |=> !o_wb.ack; endproperty
   a_ack_once: assert property (p_ack_once) else $error("long ack");
   property p_dat_idle; !o_wb.ack |-> o_wb.dat == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("idle dat");
   property p_rsv_zero;
      rdc && i_wb.adr == OFF_CMD_STAT |-> o_wb.dat[7:3] == 5'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("rsv bits");
   property p_unmapped;
      rdc && i_wb.adr == 8'hc0 |-> o_wb.dat == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_open_drain; !o_pins.scl_o && !o_pins.sda_o; endproperty
   a_open_drain: assert property (p_open_drain) else $error("drive");
   // Start only checked from an idle line; a busy transfer ignores it
   property p_prog_start;
      req && i_wb.we && i_wb.adr == OFF_CMD_STAT && i_wb.dat[0]
         && !o_pins.sda_oe && !o_pins.scl_oe
         |-> ##[1:200] o_pins.sda_oe && !o_pins.scl_oe;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("start");
   property p_irq_mask;
      req && i_wb.we && i_wb.adr == OFF_IRQ_MASK && i_wb.dat[2:0] == 3'h0
         |=> ##1 !o_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq mask");
endmodule : osc_ctrl_chk
bind osc_program_measure_ctrl osc_ctrl_chk #(.GATE_CYC(GATE_CYC)) chk_u (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb(i_wb), .o_wb(o_wb),
   .o_pins(o_pins), .o_irq(o_irq));

//--- dv/osc_program_measure_ctrl_tb.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ns
module osc_program_measure_ctrl_tb;
   import osc_ctrl_pkg::*;
   logic        i_clk_sys, i_srst, nack, irq, gen_oe, scl, sda;
   logic [3:0]  gen_clk = 4'h0;
   logic [3:0]  chan_clk;
   logic [7:0]  first;
   logic [31:0] rd;
   wb_req_t     i_wb;
   wb_rsp_t     o_wb;
   ser_pins_t   pins;
   int          num_errors = 0;
   int          num_checks = 0;
   // Both lines have pull-ups
   assign scl = !pins.scl_oe;
   assign sda = !(pins.sda_oe || gen_oe);
   osc_program_measure_ctrl #(.GATE_CYC(200)) dut_u (.i_clk_sys(i_clk_sys),
      .i_srst(i_srst), .i_wb(i_wb), .o_wb(o_wb), .i_gen_clk(gen_clk),
      .o_chan_clk(chan_clk), .i_scl(scl), .i_sda(sda), .o_pins(pins),
      .o_irq(irq));
   osc_gen_model gen_u (.i_scl(scl), .i_sda(sda), .i_nack(nack),
      .o_sda_oe(gen_oe), .o_first(first));
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = !i_clk_sys;
   end
   always @(posedge i_clk_sys) gen_clk <= ~gen_clk;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // Gate edges may land either side of the window, so allow one count
   task automatic near(input logic [23:0] got, input int exp);
      num_checks++;
      if ((got inside {[exp-1:exp+1]}) !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t count %0d exp %0d", $time, got, exp);
      end
   endtask : near
   // No limit of its own: only the watchdog ends a wait for ack
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wb <= {1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge i_clk_sys);
      end while (o_wb.ack !== 1'b1);
      rd = o_wb.dat;
      i_wb <= '0;
   endtask : bus
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFF_CMD_STAT, 32'h0000_0000);
         n++;
      end while (rd[b] !== 1'b1 && n < 2000);
      if (rd[b] !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t poll timed out", $time);
      end
   endtask : poll
   task automatic t_ram;
      bus(1'b0, OFF_CMD_STAT, 32'h0000_0000);
      cmp(rd, 32'h0000_0001);
      // Bypassed divider: channel clock is the input one cycle late
      @(negedge i_clk_sys);
      cmp({28'h000_0000, chan_clk}, {28'h000_0000, ~gen_clk});
      bus(1'b1, OFF_RAM_PTR, 32'h0000_0008);
      bus(1'b1, OFF_RAM_DATA, 32'h0000_005a);
      bus(1'b1, OFF_RAM_PTR, 32'h0000_0009);
      bus(1'b1, OFF_RAM_DATA, 32'h0000_00c3);
      bus(1'b1, OFF_RAM_PTR, 32'h0000_0008);
      bus(1'b0, OFF_RAM_DATA, 32'h0000_0000);
      cmp(rd, 32'h0000_005a);
      bus(1'b1, 8'hc0, 32'hffff_ffff);
      bus(1'b0, 8'hc0, 32'h0000_0000);
      cmp(rd, 32'h0000_0000);
   endtask : t_ram
   task automatic t_meas;
      bus(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
      for (int ch = 0; ch < 4; ch++) begin
         bus(1'b1, OFF_CMD_STAT, 32'h0032_1080 | (32'h1 << (ch + 1)));
         bus(1'b0, OFF_CMD_STAT, 32'h0000_0000);
         cmp(rd[2], 1'b0);
         poll(2);
         near(rd[31:8], 200 / (2 << ch));
      end
      cmp(irq, 1'b1);
      bus(1'b1, OFF_IRQ_STAT, 32'h0000_0004);
      @(posedge i_clk_sys);
      cmp(irq, 1'b0);
   endtask : t_meas
   task automatic t_keep;
      bus(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
      bus(1'b1, OFF_CMD_STAT, 32'h00ff_ff04);
      poll(2);
      near(rd[31:8], 50);
      cmp(irq, 1'b0);
      bus(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
      cmp(rd, 32'h0000_0004);
   endtask : t_keep
   task automatic t_prog;
      nack <= 1'b1;
      bus(1'b1, OFF_CMD_STAT, 32'h0000_0041);
      bus(1'b0, OFF_CMD_STAT, 32'h0000_0000);
      cmp(rd, 32'h3210_4004);
      poll(0);
      cmp(rd, 32'h3210_4007);
      cmp(first, 8'haa);
      bus(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
      cmp(rd, 32'h0000_0007);
   endtask : t_prog
   task automatic close_out;
      if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #1_000_000;
      num_errors++;
      close_out();
   end
   initial begin
      i_srst = 1'b1;
      i_wb = '0;
      nack = 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      t_ram();
      t_meas();
      t_keep();
      t_prog();
      close_out();
   end
endmodule : osc_program_measure_ctrl_tb
